/* File: rtl/lls_config_regs.sv */
// LIN/LON configuration and status register bank with Avalon-MM slave.
// Assumes a single clock; engine strobes are synchronous one-cycle pulses.
//
// Notes on behaviour
// RL1 - Length from identifier bits 5 and 6
// RL2 - Otherwise length is control field plus one
// RL3 - Frame slot runs when disable bit clear
// RL4 - Wakeup command sends LIN 2.0 or 1.3
// RL5 - DMA writes LIN mode except its flag
// RL6 - Slave sync unless sync-off bit set
// RL7 - Master: identifier writable and transmitted
// RL8 - Slave: identifier read-only, last received
// RL9 - Recovered baud shown after synchronization
// RL10 - Collision detect enable gates collisions
// RL11 - Type 1 terminate on collision option
// RL12 - Type 1 tail collisions ignored option
// RL13 - Comm type bit picks type 1/2
// RL14 - LON DMA mode allows length writes
// RL15 - Collision source external or internal
// RL16 - End of frame after quiet time
// RL17 - Preamble lasts programmed bit times
// RL18 - Frame data length is field plus one
// RL19 - Backlog increment placed in header
// RL20 - Priority and alternate path into header
// RL21 - Write protect blocks protected writes; DMA updates of LIN mode are not blocked
// RL22 - Registers act only in their modes; mode, preamble, length and header registers accept writes in any mode
`include "lls_regs.svh"
module lls_config_regs
(
  input  wire logic                 clk_in,
  input  wire logic                 srst_in,
  input  wire logic [31:0]          avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic [31:0]               avs_readdata_out,
  output logic                      avs_waitrequest_out,
  input  wire logic                 dma_wr_in,
  input  wire logic                 dma_sel_lon_in,
  input  wire logic [31:0]          dma_data_in,
  input  wire logic                 id_rx_vld_in,
  input  wire logic [7:0]           id_rx_in,
  input  wire logic                 sync_done_in,
  input  wire logic [15:0]          divider_in,
  input  wire logic [2:0]           fraction_in,
  input  wire logic                 col_ext_in,
  input  wire logic                 col_int_in,
  input  wire logic                 crc_sent_in,
  input  wire logic                 over_in,
  input  wire logic                 line_in,
  input  wire logic                 bit_tick_in,
  input  wire logic                 preamble_start_in,
  output lls_pkg::lls_lin_cfg_t     lin_cfg_out,
  output lls_pkg::lls_lon_cfg_t     lon_cfg_out,
  output logic                      wakeup_out,
  output logic                      collision_out,
  output logic                      terminate_out,
  output logic                      eof_out,
  output logic                      preamble_active_out
);
  import lls_pkg::*;

  logic [31:0] lin_mode_r;
  logic [7:0]  lin_id_r;
  logic [18:0] baud_r;
  logic [31:0] lon_mode_r;
  logic [13:0] lon_pre_r;
  logic [7:0]  lon_dl_r;
  logic [7:0]  lon_hdr_r;
  logic [3:0]  opmode_r;
  logic        write_protect_en_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        wake_r;
  logic        line_q_r;
  logic [12:0] eof_cnt_r;
  logic        eof_r;
  logic [13:0] pre_cnt_r;
  logic        req;
  logic        wr_ok;
  logic        is_lon;
  logic        is_lin;
  logic        is_mst;
  logic        is_slv;
  logic [12:0] eof_thr;
  logic [8:0]  id_len;
  logic        col_raw;
  logic        col_tail;

  assign is_lon = opmode_r == LLS_MODE_LON;
  assign is_mst = opmode_r == LLS_MODE_LINM;
  assign is_slv = opmode_r == LLS_MODE_LINS;
  assign is_lin = is_mst | is_slv;

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait state per access
  // ---------------------------------------------------------------
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign wr_ok = avs_write_in & ack_r;
  assign avs_readdata_out = rdata_r;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rdata_r <= `LLS_RST_ZERO;
    else if (avs_read_in & ~ack_r)
    begin
      unique case (avs_address_in)
        `LLS_ADR_LIN_MODE: rdata_r <= lin_mode_r;
        `LLS_ADR_LIN_ID:   rdata_r <= {24'h000000, lin_id_r};
        `LLS_ADR_LIN_BAUD: rdata_r <= {13'h0000, baud_r};
        `LLS_ADR_LON_MODE: rdata_r <= lon_mode_r;
        `LLS_ADR_LON_PRE:  rdata_r <= {18'h00000, lon_pre_r};
        `LLS_ADR_LON_DL:   rdata_r <= {24'h000000, lon_dl_r};
        `LLS_ADR_LON_HDR:  rdata_r <= {24'h000000, lon_hdr_r};
        `LLS_ADR_CTRL:     rdata_r <= {23'h000000, write_protect_en_r, 4'h0, opmode_r};
        default:           rdata_r <= `LLS_RST_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control: operating mode, protection, wakeup command
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      opmode_r <= 4'h0;
      write_protect_en_r   <= 1'b0;
    end
    else if (wr_ok & (avs_address_in == `LLS_ADR_CTRL))
    begin
      opmode_r <= avs_writedata_in[3:0];
      write_protect_en_r   <= avs_writedata_in[`LLS_CTRL_WRITE_PROTECT_EN];
    end
  end

  // RL4 wakeup command pulse
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      wake_r <= 1'b0;
    else
      wake_r <= wr_ok & (avs_address_in == `LLS_ADR_CTRL) & is_lin &
                avs_writedata_in[`LLS_CTRL_WAKE];
  end
  assign wakeup_out = wake_r;

  // ---------------------------------------------------------------
  // LIN registers
  // ---------------------------------------------------------------
  // RL5 DMA update keeps its flag; RL21 protect
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      lin_mode_r <= `LLS_RST_ZERO;
    else if (wr_ok & ~write_protect_en_r & (avs_address_in == `LLS_ADR_LIN_MODE))
      lin_mode_r <= avs_writedata_in & `LLS_MSK_LIN_MODE;
    else if (dma_wr_in & ~dma_sel_lon_in & lin_mode_r[`LLS_LIN_DMA_MODE_UPDATE])
    begin
      lin_mode_r <= dma_data_in & `LLS_MSK_LIN_MODE;
      lin_mode_r[`LLS_LIN_DMA_MODE_UPDATE] <= 1'b1;
    end
  end

  // RL7 master write, RL8 slave capture
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      lin_id_r <= 8'h00;
    else if (is_slv & id_rx_vld_in)
      lin_id_r <= id_rx_in;
    else if (wr_ok & is_mst & (avs_address_in == `LLS_ADR_LIN_ID))
      lin_id_r <= avs_writedata_in[7:0];
  end

  // RL9 capture recovered baud
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      baud_r <= 19'h00000;
    else if (is_lin & sync_done_in)
      baud_r <= {fraction_in, divider_in};
  end

  // RL1 length code from identifier
  always_comb
  begin
    unique case (lin_id_r[6:5])
      2'b10:   id_len = 9'h004;
      2'b11:   id_len = 9'h008;
      default: id_len = 9'h002;
    endcase
  end

  always_comb
  begin
    lin_cfg_out.node_action     = lin_mode_r[1:0];
    lin_cfg_out.identifier_char = lin_id_r;
    lin_cfg_out.wakeup_lin13    = lin_mode_r[`LLS_LIN_WKTYP];
    // RL3 frame slot in LIN modes
    lin_cfg_out.frame_slot_en   = is_lin & ~lin_mode_r[`LLS_LIN_FRAME_SLOT_OFF];
    // RL6 slave sync enable
    lin_cfg_out.slave_sync_en   = is_slv & ~lin_mode_r[`LLS_LIN_SLAVE_SYNC_OFF];
    // RL2 control field plus one
    lin_cfg_out.resp_len        = lin_mode_r[`LLS_LIN_DLM] ? id_len :
                                  {1'b0, lin_mode_r[15:8]} + 9'h001;
  end

  // ---------------------------------------------------------------
  // LON registers
  // ---------------------------------------------------------------
  // RL21 protected LON mode and preamble
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      lon_mode_r <= `LLS_RST_ZERO;
      lon_pre_r  <= 14'h0000;
    end
    else if (wr_ok & ~write_protect_en_r)
    begin
      if (avs_address_in == `LLS_ADR_LON_MODE)
        lon_mode_r <= avs_writedata_in & `LLS_MSK_LON_MODE;
      if (avs_address_in == `LLS_ADR_LON_PRE)
        lon_pre_r <= avs_writedata_in[13:0];
    end
  end

  // RL14 DMA length writes
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      lon_dl_r <= 8'h00;
    else if (wr_ok & (avs_address_in == `LLS_ADR_LON_DL))
      lon_dl_r <= avs_writedata_in[7:0];
    else if (dma_wr_in & dma_sel_lon_in & lon_mode_r[`LLS_LON_DMA_LENGTH_UPDATE])
      lon_dl_r <= dma_data_in[7:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      lon_hdr_r <= 8'h00;
    else if (wr_ok & (avs_address_in == `LLS_ADR_LON_HDR))
      lon_hdr_r <= avs_writedata_in[7:0];
  end

  always_comb
  begin
    // RL13 comm type select
    lon_cfg_out.comm_type2         = lon_mode_r[`LLS_LON_COMM_TYPE_SEL];
    lon_cfg_out.preamble_bit_count = lon_pre_r;
    // RL18 data length plus one
    lon_cfg_out.frame_len          = {1'b0, lon_dl_r} + 9'h001;
    // RL19 RL20 header layout
    lon_cfg_out.header             = lon_hdr_r;
  end

  // ---------------------------------------------------------------
  // Collision handling
  // ---------------------------------------------------------------
  // RL15 source select
  assign col_raw  = lon_mode_r[`LLS_LON_COLLISION_SOURCE_SEL] ? col_int_in : col_ext_in;
  // RL12 tail window ignore
  assign col_tail = ~lon_mode_r[`LLS_LON_COMM_TYPE_SEL] & crc_sent_in &
                    lon_mode_r[`LLS_LON_IGNORE_TAIL_COLLISIONS];
  // RL10 RL22 enable gating
  assign collision_out = is_lon & lon_mode_r[`LLS_LON_COLLISION_DETECT_EN] & col_raw &
                         ~col_tail;
  // RL11 terminate in type 1
  assign terminate_out = collision_out & ~lon_mode_r[`LLS_LON_COMM_TYPE_SEL] &
                         lon_mode_r[`LLS_LON_END_FRAME_ON_COLLISION];

  // ---------------------------------------------------------------
  // End of frame detector
  // ---------------------------------------------------------------
  // RL16 quiet time threshold
  assign eof_thr = ({5'h00, lon_mode_r[23:16]} + 13'h0001) <<
                   (over_in ? 13'h0003 : 13'h0004);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      line_q_r <= 1'b1;
    else
      line_q_r <= line_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in | ~is_lon | (line_in ^ line_q_r))
      eof_cnt_r <= 13'h0000;
    else if (eof_cnt_r < eof_thr)
      eof_cnt_r <= eof_cnt_r + 13'h0001;
  end

  // RL16 one pulse per quiet period
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      eof_r <= 1'b0;
    else
      eof_r <= is_lon & ~(line_in ^ line_q_r) &
               (eof_cnt_r == eof_thr - 13'h0001);
  end
  assign eof_out = eof_r;

  // ---------------------------------------------------------------
  // Preamble timer
  // ---------------------------------------------------------------
  // RL17 bit-time countdown
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pre_cnt_r <= 14'h0000;
    else if (preamble_start_in & is_lon)
      pre_cnt_r <= lon_pre_r;
    else if (bit_tick_in & (pre_cnt_r != 14'h0000))
      pre_cnt_r <= pre_cnt_r - 14'h0001;
  end
  assign preamble_active_out = pre_cnt_r != 14'h0000;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_len_ctrl;
    !lin_mode_r[`LLS_LIN_DLM] |->
      lin_cfg_out.resp_len == {1'b0, lin_mode_r[15:8]} + 9'h001;
  endproperty
  a_len_ctrl: assert property (p_len_ctrl) // RL2
    else $error("response length not field plus one");
  property p_slot;
    lin_cfg_out.frame_slot_en |-> is_lin && !lin_mode_r[`LLS_LIN_FRAME_SLOT_OFF];
  endproperty
  a_slot: assert property (p_slot) // RL3
    else $error("frame slot enabled wrongly");
  property p_id_wr;
    wr_ok && is_mst && avs_address_in == `LLS_ADR_LIN_ID |=>
      lin_id_r == $past(avs_writedata_in[7:0]);
  endproperty
  a_id_wr: assert property (p_id_wr) // RL7
    else $error("master identifier write lost");
  property p_id_ro;
    is_slv && !id_rx_vld_in |=> $stable(lin_id_r);
  endproperty
  a_id_ro: assert property (p_id_ro) // RL8
    else $error("slave identifier changed without reception");
  property p_wp;
    write_protect_en_r && !(dma_wr_in && !dma_sel_lon_in) |=>
      $stable(lin_mode_r) && $stable(lon_mode_r) && $stable(lon_pre_r);
  endproperty
  a_wp: assert property (p_wp) // RL21
    else $error("protected register written");
  property p_dma_lin;
    dma_wr_in && !dma_sel_lon_in && !lin_mode_r[`LLS_LIN_DMA_MODE_UPDATE] &&
      !wr_ok |=> $stable(lin_mode_r);
  endproperty
  a_dma_lin: assert property (p_dma_lin) // RL5
    else $error("LIN mode changed by DMA while disabled");
  property p_baud;
    is_lin && sync_done_in |=>
      baud_r == {$past(fraction_in), $past(divider_in)};
  endproperty
  a_baud: assert property (p_baud) // RL9
    else $error("recovered baud not captured");
  property p_term;
    terminate_out |-> collision_out && !lon_mode_r[`LLS_LON_COMM_TYPE_SEL];
  endproperty
  a_term: assert property (p_term) // RL11
    else $error("terminate outside type 1 collision");
  property p_eof;
    (line_in ^ line_q_r) |=> !eof_out;
  endproperty
  a_eof: assert property (p_eof) // RL16
    else $error("end of frame right after transition");
  property p_col_off;
    !lon_mode_r[`LLS_LON_COLLISION_DETECT_EN] |-> !collision_out;
  endproperty
  a_col_off: assert property (p_col_off) // RL10
    else $error("collision reported while disabled");
  property p_wait;
    req && avs_waitrequest_out |=> !avs_waitrequest_out || !req;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest held more than one cycle");
endmodule

/* File: rtl/lls_regs.svh */
// Offsets, field positions and reset values of the LIN/LON register bank.
// Assumes inclusion by the register bank module and the bench.
`ifndef LLS_REGS_SVH
`define LLS_REGS_SVH
// ---------------------------------------------------------------
// Byte addresses
// ---------------------------------------------------------------
`define LLS_ADR_LIN_MODE   32'h40024054
`define LLS_ADR_LIN_ID     32'h40024058
`define LLS_ADR_LIN_BAUD   32'h4002405c
`define LLS_ADR_LON_MODE   32'h40024060
`define LLS_ADR_LON_PRE    32'h40024064
`define LLS_ADR_LON_DL     32'h40024068
`define LLS_ADR_LON_HDR    32'h4002406c
`define LLS_ADR_CTRL       32'h40024100
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LLS_LIN_DLM        5
`define LLS_LIN_FRAME_SLOT_OFF      6
`define LLS_LIN_WKTYP      7
`define LLS_LIN_DMA_MODE_UPDATE       16
`define LLS_LIN_SLAVE_SYNC_OFF    17
`define LLS_LON_COMM_TYPE_SEL      0
`define LLS_LON_COLLISION_DETECT_EN     1
`define LLS_LON_END_FRAME_ON_COLLISION       2
`define LLS_LON_IGNORE_TAIL_COLLISIONS     3
`define LLS_LON_DMA_LENGTH_UPDATE       4
`define LLS_LON_COLLISION_SOURCE_SEL       5
`define LLS_CTRL_WRITE_PROTECT_EN      8
`define LLS_CTRL_WAKE      9
// ---------------------------------------------------------------
// Masks and reset values
// ---------------------------------------------------------------
`define LLS_MSK_LIN_MODE   32'h0003ffff
`define LLS_MSK_LON_MODE   32'h00ff003f
`define LLS_RST_ZERO       32'h00000000
`endif

/* File: rtl/lls_pkg.sv */
// Types shared by the LIN/LON register bank and its users.
// Assumes the engines consume the config bundles as levels.
package lls_pkg;
  typedef enum logic [3:0] {
    LLS_MODE_LON  = 4'b1001,
    LLS_MODE_LINM = 4'b1010,
    LLS_MODE_LINS = 4'b1011
  } lls_mode_t;

  typedef struct packed {
    logic       frame_slot_en;
    logic       slave_sync_en;
    logic       wakeup_lin13;
    logic [1:0] node_action;
    logic [8:0] resp_len;
    logic [7:0] identifier_char;
  } lls_lin_cfg_t;

  typedef struct packed {
    logic        comm_type2;
    logic [13:0] preamble_bit_count;
    logic [8:0]  frame_len;
    logic [7:0]  header;
  } lls_lon_cfg_t;
endpackage

/* File: sim/lls_node_model.sv */
// Far-side LIN/LON node: receive, sync, line and collision inputs.
// Assumes tasks are called from one bench process at a time.
module lls_node_model
(
  input  wire logic        clk_in,
  output logic             id_vld_out,
  output logic [7:0]       id_out,
  output logic             sync_out,
  output logic [18:0]      baud_out,
  output logic [3:0]       lvl_out,
  output logic             line_out,
  output logic             tick_out,
  output logic             pre_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {id_vld_out, id_out, sync_out, baud_out} = '0;
    {lvl_out, line_out, tick_out, pre_out} = '0;
  end

  // ----------------------------------------
  // One-cycle strobe: 0 id, 1 sync, 2 tick, 3 preamble start
  // ----------------------------------------
  task automatic strobe(input int k, input logic [18:0] v);
    @(posedge clk_in);
    if (k == 0)
      id_vld_out <= 1'b1;
    if (k == 1)
      sync_out <= 1'b1;
    if (k == 2)
      tick_out <= 1'b1;
    if (k == 3)
      pre_out <= 1'b1;
    id_out   <= v[7:0];
    baud_out <= v;
    @(posedge clk_in);
    {id_vld_out, sync_out, tick_out, pre_out} <= '0;
    // Qualified data goes stale once the strobe drops
    id_out   <= ~v[7:0];
    baud_out <= ~v;
  endtask

  task automatic toggle();
    @(posedge clk_in);
    line_out <= ~line_out;
  endtask

  // Levels: over, crc window, internal and external collision
  task automatic levels(input logic [3:0] v);
    @(posedge clk_in);
    lvl_out <= v;
  endtask
endmodule

/* File: sim/lls_config_regs_test.sv */
// Self-checking bench for the LIN/LON register bank.
// Assumes one answer per access; the node model feeds engine inputs.
`include "lls_regs.svh"
module lls_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import lls_pkg::*;

  localparam logic [31:0] CT = `LLS_ADR_CTRL;
  localparam logic [31:0] LM = `LLS_ADR_LIN_MODE;
  localparam logic [31:0] LI = `LLS_ADR_LIN_ID;
  localparam logic [31:0] LB = `LLS_ADR_LIN_BAUD;
  localparam logic [31:0] LO = `LLS_ADR_LON_MODE;
  localparam logic [31:0] LP = `LLS_ADR_LON_PRE;
  localparam logic [31:0] LD = `LLS_ADR_LON_DL;
  localparam logic [31:0] LH = `LLS_ADR_LON_HDR;

  logic          clk_in, srst_in, avs_read, avs_write, dma_wr, dma_sel;
  logic [31:0]   avs_address, avs_writedata, dma_data, avs_readdata;
  logic          id_vld, sync, line, tick, pre, avs_waitrequest;
  logic [7:0]    id;
  logic [18:0]   baud;
  logic [3:0]    lvl;
  logic          wakeup, collision, terminate, eof, pre_active;
  lls_lin_cfg_t  lin_cfg;
  lls_lon_cfg_t  lon_cfg;
  int            n_fail, n_tests, cnt, n, thr;
  int            lens[4] = '{2, 2, 4, 8};
  logic [15:0]   ctab[8] = '{16'h0212, 16'h0220, 16'h2222, 16'h2030,
                             16'h0613, 16'h0712, 16'h0a50, 16'h0252};

  lls_config_regs lls_config_regs_inst (
    .clk_in(clk_in), .srst_in(srst_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .dma_wr_in(dma_wr),
    .dma_sel_lon_in(dma_sel), .dma_data_in(dma_data),
    .id_rx_vld_in(id_vld), .id_rx_in(id), .sync_done_in(sync),
    .divider_in(baud[15:0]), .fraction_in(baud[18:16]),
    .col_ext_in(lvl[0]), .col_int_in(lvl[1]), .crc_sent_in(lvl[2]),
    .over_in(lvl[3]), .line_in(line), .bit_tick_in(tick),
    .preamble_start_in(pre), .lin_cfg_out(lin_cfg),
    .lon_cfg_out(lon_cfg), .wakeup_out(wakeup),
    .collision_out(collision), .terminate_out(terminate),
    .eof_out(eof), .preamble_active_out(pre_active));

  lls_node_model lls_node_model_inst (
    .clk_in(clk_in), .id_vld_out(id_vld), .id_out(id),
    .sync_out(sync), .baud_out(baud), .lvl_out(lvl),
    .line_out(line), .tick_out(tick), .pre_out(pre));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Bus, DMA and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge clk_in);
    avs_read      <= ~w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    // The wait ends only when waitrequest drops; the watchdog catches a hang
    do
      @(posedge clk_in);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk_in);
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic dma(input logic [31:0] v, input logic s);
    @(posedge clk_in);
    dma_wr   <= 1'b1;
    dma_sel  <= s;
    dma_data <= v;
    @(posedge clk_in);
    dma_wr   <= 1'b0;
    dma_data <= ~v;
    @(negedge clk_in);
  endtask

  task automatic results();
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (12000) @(posedge clk_in);
    n_fail++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    srst_in = 1'b1;
    {avs_read, avs_write, dma_wr, dma_sel} = '0;
    {avs_address, avs_writedata, dma_data} = '0;
    n_fail  = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    chk(lin_cfg.resp_len, 1);
    chk(lon_cfg.frame_len, 1);
    rc(32'h40024090, 0);
    wr(CT, 'ha);
    wr(LM, 'hffffffff);
    rc(LM, `LLS_MSK_LIN_MODE);
    wr(LM, 'hff00);
    chk(lin_cfg.resp_len, 'h100);
    chk(lin_cfg.frame_slot_en, 1);
    wr(LM, 'hc0);
    chk(lin_cfg.resp_len, 1);
    chk(lin_cfg.frame_slot_en, 0);
    chk(lin_cfg.wakeup_lin13, 1);
    wr(CT, 'h20a);
    cnt = 0;
    repeat (4)
    begin
      if (wakeup === 1'b1)
        cnt++;
      @(negedge clk_in);
    end
    chk(cnt, 1);
    rc(CT, 'ha);
    wr(LM, 'h20);
    for (int i = 0; i < 4; i++)
    begin
      wr(LI, {25'h0, i[1:0], 5'h15});
      chk(lin_cfg.resp_len, lens[i]);
      chk(lin_cfg.identifier_char, {1'b0, i[1:0], 5'h15});
      rc(LI, {25'h0, i[1:0], 5'h15});
    end
    wr(CT, 'hb);
    lls_node_model_inst.strobe(0, 'h3c);
    @(negedge clk_in);
    rc(LI, 'h3c);
    wr(LI, 'h55);
    rc(LI, 'h3c);
    wr(LM, 'h20000);
    chk(lin_cfg.slave_sync_en, 0);
    wr(LM, 0);
    chk(lin_cfg.slave_sync_en, 1);
    lls_node_model_inst.strobe(1, 'h51234);
    @(negedge clk_in);
    rc(LB, 'h51234);
    wr(LB, 0);
    rc(LB, 'h51234);
    dma('hff00, 0);
    rc(LM, 0);
    wr(LM, 'h10000);
    dma('h0f01, 0);
    rc(LM, 'h10f01);
    chk(lin_cfg.node_action, 1);
    wr(CT, 'h9);
    wr(LO, 'hffffffff);
    rc(LO, `LLS_MSK_LON_MODE);
    chk(lon_cfg.comm_type2, 1);
    wr(LO, 0);
    chk(lon_cfg.comm_type2, 0);
    wr(LP, 'h3fff);
    rc(LP, 'h3fff);
    chk(lon_cfg.preamble_bit_count, 'h3fff);
    wr(LD, 'hff);
    chk(lon_cfg.frame_len, 'h100);
    dma('h10, 1);
    rc(LD, 'hff);
    wr(LO, 'h10);
    dma('h10, 1);
    rc(LD, 'h10);
    wr(LH, 'hc5);
    rc(LH, 'hc5);
    chk(lon_cfg.header, 'hc5);
    foreach (ctab[i])
    begin
      wr(LO, {24'h0, ctab[i][15:8]});
      lls_node_model_inst.levels(ctab[i][7:4]);
      @(negedge clk_in);
      chk(collision, ctab[i][1]);
      chk(terminate, ctab[i][0]);
    end
    lls_node_model_inst.levels(0);
    wr(CT, 'h109);
    wr(LO, 1);
    rc(LO, 'h02);
    wr(LP, 1);
    rc(LP, 'h3fff);
    wr(LM, 0);
    rc(LM, 'h10f01);
    wr(LD, 7);
    rc(LD, 7);
    wr(CT, 'h9);
    wr(LP, 3);
    lls_node_model_inst.strobe(3, 0);
    @(negedge clk_in);
    chk(pre_active, 1);
    repeat (2) lls_node_model_inst.strobe(2, 0);
    @(negedge clk_in);
    chk(pre_active, 1);
    lls_node_model_inst.strobe(2, 0);
    @(negedge clk_in);
    chk(pre_active, 0);
    for (int k = 0; k < 2; k++)
    begin
      wr(LO, k ? 'h10000 : 0);
      lls_node_model_inst.levels(k ? 4'h0 : 4'h8);
      thr = k ? 32 : 8;
      lls_node_model_inst.toggle();
      n = 0;
      while (eof !== 1'b1 && n < 600)
      begin
        @(negedge clk_in);
        n++;
      end
      chk(n >= thr && n <= thr + 2, 1);
    end
    wr(CT, 'ha);
    lls_node_model_inst.toggle();
    cnt = 0;
    repeat (60)
    begin
      @(negedge clk_in);
      if (eof !== 1'b0)
        cnt++;
    end
    chk(cnt, 0);
    results();
  end
endmodule
